// ---- hw/cvc_fixed_sel.sv ----
// Fixed command value selector.
// Assumes selection inputs are already synchronous to clk.
`timescale 1ns/1ps
module cvc_fixed_sel
  import cvc_pkg::*;
(
  // Control
  input  wire logic                fix_en,
  input  wire logic [2:0]          sel_used,
  input  wire logic [2:0]          sel_in,
  // Values
  input  wire logic signed [15:0]  ext_cmd,
  input  wire logic signed [15:0]  fix_val [N_FIXED],
  output logic signed [15:0]       sel_cmd,
  output logic [2:0]               sel_idx
);
  logic [2:0] eff;                        // Gated selection bits

  // Gate each selection by its own use; bit 1 also needs bit 0 used, bit 2 needs bit 0 or bit 1 used
  always_comb begin
    eff[0] = sel_used[0] & sel_in[0];
    eff[1] = sel_used[1] & sel_used[0] & sel_in[1];
    eff[2] = sel_used[2] & (sel_used[0] | sel_used[1])
             & sel_in[2];
  end

  // Index zero keeps the external value
  always_comb begin
    sel_idx = fix_en ? eff : 3'h0;
    if (sel_idx == 3'h0) begin
      sel_cmd = ext_cmd;
    end else begin
      sel_cmd = fix_val[sel_idx - 3'h1];
    end
  end
endmodule // cvc_fixed_sel

// ---- hw/cvc_pkg.sv ----
// Constants for the command value conditioning block.
// Assumes one 20 MHz system clock; values are fixed-point integers.
package cvc_pkg;
  // Clock period in ns, kept for timing reference
  localparam int CLK_PERIOD_NS = 50;
  // Signal type codes
  localparam logic [1:0] SIG_VOLT = 2'h0;
  localparam logic [1:0] SIG_CURR = 2'h1;
  localparam logic [1:0] SIG_FREQ = 2'h2;
  localparam logic [1:0] SIG_PWM  = 2'h3;
  // Input level units: mV, uA, 0.2 Hz, 0.1 %PW (signed 16 bit)
  // Frequency counts in 0.2 Hz so 5000 Hz still fits a signed word
  localparam int LVL_W = 16;
  // Endpoint limits and steps per type
  localparam logic signed [15:0] VOLT_MIN_BI   = -16'sd10000;
  localparam logic signed [15:0] VOLT_MIN_UNI  = 16'sd0;
  localparam logic signed [15:0] VOLT_MAX      = 16'sd10000;
  localparam logic signed [15:0] VOLT_STEP     = 16'sd200;
  localparam logic signed [15:0] FREQ_MIN      = 16'sd25;
  localparam logic signed [15:0] FREQ_MAX      = 16'sd25000;
  localparam logic signed [15:0] PWM_MIN       = 16'sd0;
  localparam logic signed [15:0] PWM_MAX       = 16'sd1000;
  localparam logic signed [15:0] PWM_STEP      = 16'sd2;
  // Default endpoints per type: volt, curr, freq, pwm
  localparam logic signed [15:0] DEF_MIN_IF [4] =
    '{16'sd0, 16'sd0, 16'sd25, 16'sd50};
  localparam logic signed [15:0] DEF_MAX_IF [4] =
    '{16'sd10000, 16'sd20000, 16'sd25000, 16'sd950};
  localparam logic signed [15:0] DEF_CB_LO [4] =
    '{16'sd500, 16'sd500, 16'sd50, 16'sd100};
  localparam logic signed [15:0] DEF_CB_HI [4] =
    '{16'sd10000, 16'sd20000, 16'sd25000, 16'sd1000};
  // Reference values in 0.01 mm, deadband in 0.1 % of range
  localparam logic signed [15:0] DEF_MIN_REF = 16'sd0;
  localparam logic signed [15:0] DEF_MAX_REF = 16'sd10000;
  localparam logic [9:0]         DB_MAX      = 10'd1000;
  localparam int                 N_FIXED     = 7;
  // Controller mode codes that allow deadband changes
  localparam logic [1:0] MODE_PQ_OPEN  = 2'h0;
  localparam logic [1:0] MODE_POS_OPEN = 2'h1;
endpackage

// ---- hw/cvc_top.sv ----
// Command value conditioning: scaling, cable break, merge, deadband, fixed.
// Assumes synchronous inputs, one clock, and a solenoid stage downstream.
`timescale 1ns/1ps
module cvc_top
  import cvc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // Configuration
  input  wire logic [1:0]         sig_type,
  input  wire logic               bipolar,
  input  wire logic               cfg_wr,
  input  wire logic signed [15:0] cfg_min_if,
  input  wire logic signed [15:0] cfg_max_if,
  input  wire logic signed [15:0] cfg_cb_lo,
  input  wire logic signed [15:0] cfg_cb_hi,
  input  wire logic signed [15:0] min_ref,
  input  wire logic signed [15:0] max_ref,
  // Deadband control
  input  wire logic [1:0]         ctrl_mode,
  input  wire logic               db_wr,
  input  wire logic               db_en_in,
  input  wire logic [9:0]         db_thr_in,
  // Command inputs
  input  wire logic signed [15:0] cmd_level,
  input  wire logic signed [15:0] cmd2_value,
  input  wire logic               cmd2_add,
  // Fixed command selection
  input  wire logic               fix_en,
  input  wire logic [2:0]         sel_used,
  input  wire logic [2:0]         sel_in,
  input  wire logic signed [15:0] fix_val [N_FIXED],
  // Outputs
  output logic signed [15:0]      cmd_out,
  output logic                    sol_on,
  output logic                    cable_break,
  output logic signed [15:0]      min_if_out,
  output logic signed [15:0]      max_if_out,
  output logic [2:0]              fix_idx
);
  // Whole state of the block
  typedef struct packed {
    logic [1:0]         type_r;       // Last seen signal type
    logic signed [15:0] min_if_r;     // Interface low endpoint
    logic signed [15:0] max_if_r;     // Interface high endpoint
    logic signed [15:0] cb_lo_r;      // Cable break low limit
    logic signed [15:0] cb_hi_r;      // Cable break high limit
    logic               db_en_r;      // Deadband switched on
    logic [9:0]         db_thr_r;     // Deadband threshold, 0.1 %
    logic signed [15:0] out_r;        // Conditioned command
    logic               sol_r;        // Solenoid current allowed
    logic               cb_r;         // Cable break flag
    logic [2:0]         idx_r;        // Active fixed index
  } cvc_state_t;

  cvc_state_t st_r, st_nxt;

  logic signed [15:0] lo_lim;         // Lower bound for this type
  logic signed [15:0] hi_lim;         // Upper bound for this type
  logic signed [15:0] step;           // Endpoint step for this type
  logic signed [47:0] num;            // Scaling numerator
  logic signed [31:0] den;            // Interface span
  logic signed [31:0] scaled;         // Scaled command
  logic signed [31:0] merged;         // After second source
  logic signed [15:0] clamped;        // Reference-range result
  logic signed [15:0] sel_cmd;        // After fixed selection
  logic [2:0]         sel_idx;        // Selector index
  logic [31:0]        db_lvl;         // Deadband level in ref units
  logic [31:0]        rel;            // Command above min reference

  // Fixed command selector
  cvc_fixed_sel u_sel (
    .fix_en  (fix_en),
    .sel_used(sel_used),
    .sel_in  (sel_in),
    .ext_cmd (clamped),
    .fix_val (fix_val),
    .sel_cmd (sel_cmd),
    .sel_idx (sel_idx)
  );

  // Legal endpoint range by signal type
  always_comb begin
    case (sig_type)
      SIG_VOLT: begin
        lo_lim = bipolar ? VOLT_MIN_BI : VOLT_MIN_UNI;
        hi_lim = VOLT_MAX;
        step   = VOLT_STEP;
      end
      SIG_FREQ: begin
        lo_lim = FREQ_MIN;
        hi_lim = FREQ_MAX;
        step   = 16'sd1;
      end
      SIG_PWM: begin
        lo_lim = PWM_MIN;
        hi_lim = PWM_MAX;
        step   = PWM_STEP;
      end
      default: begin
        lo_lim = 16'sd0;
        hi_lim = DEF_MAX_IF[SIG_CURR];
        step   = 16'sd1;
      end
    endcase
  end

  // Linear scaling, merge, clamp
  always_comb begin
    den = 32'(st_r.max_if_r) - 32'(st_r.min_if_r);
    num = 48'(32'(cmd_level) - 32'(st_r.min_if_r))
          * 48'(32'(max_ref) - 32'(min_ref));
    if (den == 32'sd0) begin
      scaled = 32'(min_ref);
    end else begin
      scaled = 32'(num / 48'(den)) + 32'(min_ref);
    end
    merged = cmd2_add ? scaled + 32'(cmd2_value) : scaled;
    // Relies on min below max reference for a sane clamp
    if (merged < 32'(min_ref)) begin
      clamped = min_ref;
    end else if (merged > 32'(max_ref)) begin
      clamped = max_ref;
    end else begin
      clamped = merged[15:0];
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.type_r = sig_type;
    if (sig_type != st_r.type_r) begin
      // Type change discards user endpoints
      st_nxt.min_if_r = DEF_MIN_IF[sig_type];
      st_nxt.max_if_r = DEF_MAX_IF[sig_type];
      st_nxt.cb_lo_r  = DEF_CB_LO[sig_type];
      st_nxt.cb_hi_r  = DEF_CB_HI[sig_type];
    end else if (cfg_wr && cfg_min_if >= lo_lim && cfg_max_if <= hi_lim
                 && (cfg_min_if % step) == 16'sd0
                 && (cfg_max_if % step) == 16'sd0) begin
      // Off-grid writes, or a min below or max above the type range, are dropped
      st_nxt.min_if_r = cfg_min_if;
      st_nxt.max_if_r = cfg_max_if;
      st_nxt.cb_lo_r  = cfg_cb_lo;
      st_nxt.cb_hi_r  = cfg_cb_hi;
    end
    if (db_wr && db_thr_in <= DB_MAX &&
        (ctrl_mode == MODE_PQ_OPEN || ctrl_mode == MODE_POS_OPEN)) begin
      st_nxt.db_en_r  = db_en_in;
      st_nxt.db_thr_r = db_thr_in;
    end
    st_nxt.cb_r = (cmd_level < st_r.cb_lo_r) ||
                  (cmd_level > st_r.cb_hi_r);
    st_nxt.idx_r = sel_idx;
    // Deadband on merged/selected command
    db_lvl = 32'((64'(unsigned'(32'(max_ref) - 32'(min_ref)))
                  * 64'(st_r.db_thr_r)) / 64'(DB_MAX));
    rel = unsigned'(32'(sel_cmd) - 32'(min_ref));
    if (st_r.db_en_r && rel < db_lvl) begin
      st_nxt.out_r = min_ref;
      st_nxt.sol_r = 1'b0;
    end else begin
      st_nxt.out_r = sel_cmd;
      st_nxt.sol_r = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r.type_r   <= SIG_VOLT;
      st_r.min_if_r <= DEF_MIN_IF[SIG_VOLT];
      st_r.max_if_r <= DEF_MAX_IF[SIG_VOLT];
      st_r.cb_lo_r  <= DEF_CB_LO[SIG_VOLT];
      st_r.cb_hi_r  <= DEF_CB_HI[SIG_VOLT];
      st_r.db_en_r  <= 1'b0;
      st_r.db_thr_r <= 10'h000;
      st_r.out_r    <= 16'sh0000;
      st_r.sol_r    <= 1'b0;
      st_r.cb_r     <= 1'b0;
      st_r.idx_r    <= 3'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state
  assign cmd_out     = st_r.out_r;
  assign sol_on      = st_r.sol_r;
  assign cable_break = st_r.cb_r;
  assign min_if_out  = st_r.min_if_r;
  assign max_if_out  = st_r.max_if_r;
  assign fix_idx     = st_r.idx_r;

  // Checks
  property p_type_reload;
    @(posedge clk) disable iff (sys_rst)
      (sig_type != st_r.type_r) |=> min_if_out == DEF_MIN_IF[$past(sig_type)];
  endproperty
  a_type_reload: assert property (p_type_reload)
    else $error("endpoint not reloaded");

  property p_cb;
    @(posedge clk) disable iff (sys_rst)
      (cmd_level > st_r.cb_hi_r) |=> cable_break;
  endproperty
  a_cb: assert property (p_cb)
    else $error("cable break missed");

  property p_db_lock;
    @(posedge clk) disable iff (sys_rst)
      (ctrl_mode != MODE_PQ_OPEN && ctrl_mode != MODE_POS_OPEN)
      |=> $stable(st_r.db_thr_r) && $stable(st_r.db_en_r);
  endproperty
  a_db_lock: assert property (p_db_lock)
    else $error("deadband changed in closed loop");

  property p_pass;
    @(posedge clk) disable iff (sys_rst)
      (!fix_en && !st_r.db_en_r) |=> cmd_out == $past(clamped);
  endproperty
  a_pass: assert property (p_pass)
    else $error("command not passed through");

  property p_sel2;
    @(posedge clk) disable iff (sys_rst)
      !sel_used[0] |=> !fix_idx[1] && !fix_idx[0];
  endproperty
  a_sel2: assert property (p_sel2)
    else $error("selection two active without one");

  property p_zero_sol;
    @(posedge clk) disable iff (sys_rst)
      !sol_on |-> $past(st_r.db_en_r) || $past(sys_rst);
  endproperty
  a_zero_sol: assert property (p_zero_sol)
    else $error("solenoid off without deadband");

  property p_clamp;
    @(posedge clk) disable iff (sys_rst)
      (min_ref < max_ref) |-> clamped >= min_ref && clamped <= max_ref;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("scaled value out of range");

  property p_fix;
    @(posedge clk) disable iff (sys_rst)
      (fix_en && sel_used[0] && sel_in == 3'h1) |=> fix_idx == 3'h1;
  endproperty
  a_fix: assert property (p_fix)
    else $error("fixed value one not chosen");

  c_type:  cover property (@(posedge clk) sig_type != st_r.type_r);
  c_cb:    cover property (@(posedge clk) cable_break);
  c_db:    cover property (@(posedge clk) st_r.db_en_r && !sol_on);
  c_fix7:  cover property (@(posedge clk) fix_idx == 3'h7);
endmodule // cvc_top

// ---- testbench/cvc_src_model.sv ----
// Far side model: command sources, selection inputs, reference setup.
// Assumes the bench posts requests; lines change on the falling edge.
`timescale 1ns/1ps
module cvc_src_model
  import cvc_pkg::*;
(
  // Clock
  input  wire logic               clk,
  // Requests from the bench
  input  wire logic signed [15:0] lvl_req,
  input  wire logic signed [15:0] c2_req,
  input  wire logic               add_req,
  input  wire logic [2:0]         sel_req,
  // Lines into the block
  output logic signed [15:0]      cmd_level,
  output logic signed [15:0]      cmd2_value,
  output logic                    cmd2_add,
  output logic [2:0]              sel_in,
  output logic signed [15:0]      min_ref,
  output logic signed [15:0]      max_ref
);
  // Reference span fixed; min held strictly below max
  assign min_ref = DEF_MIN_REF;
  assign max_ref = DEF_MAX_REF;
  // Sources settle one falling edge after a request, as a slow sender
  always @(negedge clk) begin
    cmd_level  <= lvl_req;
    cmd2_value <= c2_req;
    cmd2_add   <= add_req;
    sel_in     <= sel_req;
  end
endmodule // cvc_src_model

// ---- testbench/tb_command_value_conditioning.sv ----
// Self-checking bench for the command value conditioning block.
// Assumes registered outputs; checks wait two falling edges after reset, at least four after other stimuli.
`timescale 1ns/1ps
module tb_command_value_conditioning
  import cvc_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, bipolar = 1'b0, cfg_wr = 1'b0;
  logic [1:0] sig_type = SIG_VOLT, ctrl_mode = MODE_PQ_OPEN;
  logic db_wr = 1'b0, db_en_in = 1'b0, fix_en = 1'b0, add_req = 1'b0;
  logic [9:0] db_thr_in = 10'h000;
  logic [2:0] sel_used = 3'h0, sel_req = 3'h0, sel_in, fix_idx;
  logic signed [15:0] cfg_min_if = 16'sh0000, cfg_max_if = 16'sh0000;
  logic signed [15:0] cfg_cb_lo = 16'sh0000, cfg_cb_hi = 16'sh0000;
  logic signed [15:0] lvl_req = 16'sh0000, c2_req = 16'sh0000;
  logic signed [15:0] cmd_level, cmd2_value, min_ref, max_ref, cmd_out;
  logic signed [15:0] min_if_out, max_if_out, fv [N_FIXED];
  logic cmd2_add, sol_on, cable_break;
  int mismatches = 0, checks = 0, cyc = 0;
  // Clock, 50 ns period
  always #25 clk = ~clk;
  cvc_src_model src_u (.clk(clk), .lvl_req(lvl_req), .c2_req(c2_req),
    .add_req(add_req), .sel_req(sel_req), .cmd_level(cmd_level),
    .cmd2_value(cmd2_value), .cmd2_add(cmd2_add), .sel_in(sel_in),
    .min_ref(min_ref), .max_ref(max_ref));
  cvc_top dut_u (.clk(clk), .sys_rst(sys_rst), .sig_type(sig_type),
    .bipolar(bipolar), .cfg_wr(cfg_wr), .cfg_min_if(cfg_min_if),
    .cfg_max_if(cfg_max_if), .cfg_cb_lo(cfg_cb_lo), .cfg_cb_hi(cfg_cb_hi),
    .min_ref(min_ref), .max_ref(max_ref), .ctrl_mode(ctrl_mode),
    .db_wr(db_wr), .db_en_in(db_en_in), .db_thr_in(db_thr_in),
    .cmd_level(cmd_level), .cmd2_value(cmd2_value), .cmd2_add(cmd2_add),
    .fix_en(fix_en), .sel_used(sel_used), .sel_in(sel_in), .fix_val(fv),
    .cmd_out(cmd_out), .sol_on(sol_on), .cable_break(cable_break),
    .min_if_out(min_if_out), .max_if_out(max_if_out), .fix_idx(fix_idx));
  // Compare one value, report at once on mismatch
  task automatic chk(input logic signed [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Post a command, let source and block settle
  task automatic cmd(input logic signed [15:0] l, c, input logic a);
    lvl_req = l;
    c2_req = c;
    add_req = a;
    tick(4);
  endtask
  // One-cycle configuration write pulse
  task automatic wr_cfg(input logic signed [15:0] lo, hi);
    cfg_min_if = lo;
    cfg_max_if = hi;
    cfg_cb_lo = lo;
    cfg_cb_hi = hi;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(3);
  endtask
  // One-cycle deadband write pulse
  task automatic wr_db(input logic en, input logic [9:0] thr);
    db_en_in = en;
    db_thr_in = thr;
    db_wr = 1'b1;
    tick(1);
    db_wr = 1'b0;
    tick(3);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Linear scaling, clamp and cable break at voltage defaults
  task automatic t_scale();
    chk(min_if_out, 16'sh0000);
    chk(max_if_out, 16'sh2710);
    cmd(16'sh1388, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh1388);
    chk({15'h0000, cable_break}, 16'sh0001 - 16'sh0001);
    cmd(16'sh2EE0, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh2710);
    chk({15'h0000, cable_break}, 16'sh0001);
    cmd(16'sh00C8, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh00C8);
    chk({15'h0000, cable_break}, 16'sh0001);
  endtask
  // Bipolar endpoints, off-grid refusal, type defaults
  task automatic t_cfg();
    bipolar = 1'b1;
    wr_cfg(16'shD8F0, 16'sh2710);
    chk(min_if_out, 16'shD8F0);
    cmd(16'sh0000, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh1388);
    wr_cfg(16'shD954, 16'sh2710);
    chk(min_if_out, 16'shD8F0);
    sig_type = SIG_FREQ;
    tick(4);
    chk(min_if_out, 16'sh0019);
    chk(max_if_out, 16'sh61A8);
    sig_type = SIG_PWM;
    tick(4);
    chk(min_if_out, 16'sh0032);
    chk(max_if_out, 16'sh03B6);
    wr_cfg(16'sh0000, 16'sh03E8);
    chk(max_if_out, 16'sh03E8);
    wr_cfg(16'sh0000, 16'sh03EA);
    chk(max_if_out, 16'sh03E8);
    sig_type = SIG_CURR;
    tick(4);
    chk(max_if_out, 16'sh4E20);
    sig_type = SIG_VOLT;
    bipolar = 1'b0;
    tick(4);
    chk(min_if_out, 16'sh0000);
    chk(max_if_out, 16'sh2710);
  endtask
  // Deadband on merged command, writable only in open loop
  task automatic t_db();
    wr_db(1'b1, 10'h064);
    cmd(16'sh01F4, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh0000);
    chk({15'h0000, sol_on}, 16'sh0000);
    cmd(16'sh01F4, 16'sh0258, 1'b1);
    chk(cmd_out, 16'sh044C);
    chk({15'h0000, sol_on}, 16'sh0001);
    ctrl_mode = 2'h2;
    wr_db(1'b0, 10'h000);
    cmd(16'sh01F4, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh0000);
    ctrl_mode = MODE_POS_OPEN;
    wr_db(1'b0, 10'h000);
    tick(1);
    chk(cmd_out, 16'sh01F4);
  endtask
  // Fixed values by selection index and gating
  task automatic t_fix();
    cmd(16'sh1388, 16'sh0000, 1'b0);
    chk(cmd_out, 16'sh1388);
    fix_en = 1'b1;
    sel_used = 3'h7;
    for (int k = 0; k < 8; k++) begin
      sel_req = 3'(k);
      tick(4);
      chk({13'h0000, fix_idx}, 16'(k));
      chk(cmd_out, (k == 0) ? 16'sh1388 : fv[k-1]);
    end
    sel_used = 3'h6;
    tick(4);
    chk({13'h0000, fix_idx}, 16'sh0004);
    sel_used = 3'h3;
    tick(4);
    chk({13'h0000, fix_idx}, 16'sh0003);
    sel_used = 3'h4;
    tick(4);
    chk(cmd_out, 16'sh1388);
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < N_FIXED; i++) fv[i] = 16'sh03E8 + 16'(i * 100);
    tick(10);
    sys_rst = 1'b0;
    tick(2);
    chk(cmd_out, 16'sh0000);
    t_scale();
    t_cfg();
    t_db();
    t_fix();
    print_verdict();
  end
endmodule // tb_command_value_conditioning
